/* acm_pkg.sv */
// Purpose: shared constants for the entry match and port binding block
// Assumes: 32-bit Avalon-MM register words, byte addresses
// Notes:   entry modes are small encoded fields inside entry words
package acm_pkg;
  localparam int NUM_PORTS = 8;
  localparam int NUM_ENT   = 8;
  localparam int ENT_WORDS = 22;
  localparam int ADDR_W    = 12;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STAT   = 12'h004;
  localparam logic [11:0] OFS_HITCNT = 12'h008;
  localparam logic [11:0] OFS_FRMCNT = 12'h00C;
  localparam logic [11:0] OFS_BIND   = 12'h040;
  localparam logic [11:0] OFS_ENT    = 12'h100;
  localparam int          ENT_STRIDE_W = 32;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;

  // entry word indices
  localparam int W_CTRL = 0;
  localparam int W_CRIT = 1;
  localparam int W_VAL  = 2;
  localparam int W_ICMP = 3;
  localparam int W_SPRT = 4;
  localparam int W_DPRT = 5;
  localparam int W_SRC  = 6;
  localparam int W_SMSK = 10;
  localparam int W_DST  = 14;
  localparam int W_DMSK = 18;

  // field positions
  localparam int F_VALID = 0;
  localparam int F_KIND  = 1;
  localparam int F_LIST  = 3;
  localparam int F_ACT   = 6;
  localparam int F_SEQ   = 8;
  localparam int F_SYN   = 0;
  localparam int F_FIN   = 2;
  localparam int F_TOS   = 4;
  localparam int F_PRO   = 6;
  localparam int F_ICD   = 8;
  localparam int F_ITY   = 9;
  localparam int F_SPR   = 10;
  localparam int F_DPR   = 11;
  localparam int F_DSCP  = 0;
  localparam int F_PREC  = 8;
  localparam int F_PROTO = 16;
  localparam int F_PLIST = 24;
  localparam int F_ITYPE = 0;
  localparam int F_ICODE = 8;
  localparam int B_LIST  = 0;
  localparam int B_VALID = 3;

  // mode encodings
  localparam logic [1:0] FLAG_DC   = 2'h0;
  localparam logic [1:0] FLAG_SET  = 2'h1;
  localparam logic [1:0] FLAG_UNS  = 2'h2;
  localparam logic [1:0] TOS_ANY   = 2'h0;
  localparam logic [1:0] TOS_DSCP  = 2'h1;
  localparam logic [1:0] TOS_PREC  = 2'h2;
  localparam logic [1:0] PRO_ANY   = 2'h0;
  localparam logic [1:0] PRO_VAL   = 2'h1;
  localparam logic [1:0] PRO_LIST  = 2'h2;
  localparam logic [1:0] KIND_MAC  = 2'h0;
  localparam logic [1:0] KIND_IPV4 = 2'h1;
  localparam logic [1:0] KIND_IPV6 = 2'h2;

  localparam logic [7:0] PROTO_ICMP  = 8'h01;
  localparam logic [7:0] PROTO_TCP   = 8'h06;
  localparam logic [7:0] PROTO_UDP   = 8'h11;
  localparam logic [7:0] PROTO_ICMP6 = 8'h3A;
  // predefined protocol list, bit i of the list mask selects entry i
  localparam logic [7:0] PLIST [8] = '{8'h01, 8'h02, 8'h06, 8'h11,
                                       8'h29, 8'h2F, 8'h32, 8'h3A};

  function automatic logic acm_flag_ok(input logic [1:0] mode, input logic bit_v);
    acm_flag_ok = (mode == FLAG_DC) || ((mode == FLAG_SET) && bit_v) ||
                  ((mode == FLAG_UNS) && !bit_v);
  endfunction

  // wildcard bits set to one are left out of the compare
  function automatic logic acm_addr_ok(input logic [127:0] a, input logic [127:0] e,
                                       input logic [127:0] wild);
    acm_addr_ok = ((a ^ e) & ~wild) == 128'h0;
  endfunction

  function automatic logic acm_plist_hit(input logic [7:0] sel, input logic [7:0] proto);
    acm_plist_hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (sel[i] && (PLIST[i] == proto)) acm_plist_hit = 1'b1;
    end
  endfunction
endpackage

/* acm_entry_cmp.sv */
// Purpose: compare one frame header against the criteria of one entry
// Assumes: frame fields stable during the cycle of frm_valid
// Notes:   combinational; clock only samples the local checks
`timescale 1ns/1ps
module acm_entry_cmp
  import acm_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [31:0]  ent [ENT_WORDS],
  input  wire logic         f_ipv6,
  input  wire logic [7:0]   f_proto,
  input  wire logic [7:0]   f_tos,
  input  wire logic         f_syn,
  input  wire logic         f_fin,
  input  wire logic [15:0]  f_sport,
  input  wire logic [15:0]  f_dport,
  input  wire logic [7:0]   f_itype,
  input  wire logic [7:0]   f_icode,
  input  wire logic [127:0] f_src,
  input  wire logic [127:0] f_dst,
  output logic              crit_hit
);
  logic [1:0]   syn_m, fin_m, tos_m, pro_m, kind;
  logic         is_tcp, is_icmp, l4_ports;
  logic         syn_ok, fin_ok, tos_ok, pro_ok, icd_ok, ity_ok, prt_ok, adr_ok;
  logic [127:0] e_src, e_smk, e_dst, e_dmk;

  assign syn_m = ent[W_CRIT][F_SYN +: 2];
  assign fin_m = ent[W_CRIT][F_FIN +: 2];
  assign tos_m = ent[W_CRIT][F_TOS +: 2];
  assign pro_m = ent[W_CRIT][F_PRO +: 2];
  assign kind  = ent[W_CTRL][F_KIND +: 2];
  assign e_src = {ent[W_SRC+3], ent[W_SRC+2], ent[W_SRC+1], ent[W_SRC]};
  assign e_smk = {ent[W_SMSK+3], ent[W_SMSK+2], ent[W_SMSK+1], ent[W_SMSK]};
  assign e_dst = {ent[W_DST+3], ent[W_DST+2], ent[W_DST+1], ent[W_DST]};
  assign e_dmk = {ent[W_DMSK+3], ent[W_DMSK+2], ent[W_DMSK+1], ent[W_DMSK]};

  assign is_tcp   = (f_proto == PROTO_TCP);
  assign is_icmp  = f_ipv6 ? (f_proto == PROTO_ICMP6) : (f_proto == PROTO_ICMP);
  assign l4_ports = is_tcp || (f_proto == PROTO_UDP);

  // flags only mean something on tcp; other frames pass these checks
  assign syn_ok = !is_tcp || acm_flag_ok(syn_m, f_syn);
  assign fin_ok = !is_tcp || acm_flag_ok(fin_m, f_fin);
  always_comb begin
    unique case (tos_m)
      TOS_DSCP: tos_ok = (f_tos[7:2] == ent[W_VAL][F_DSCP +: 6]);
      TOS_PREC: tos_ok = (f_tos[7:5] == ent[W_VAL][F_PREC +: 3]);
      default:  tos_ok = 1'b1;
    endcase
  end
  always_comb begin
    unique case (pro_m)
      PRO_VAL:  pro_ok = (f_proto == ent[W_VAL][F_PROTO +: 8]);
      PRO_LIST: pro_ok = acm_plist_hit(ent[W_VAL][F_PLIST +: 8], f_proto);
      default:  pro_ok = 1'b1;
    endcase
  end
  assign icd_ok = !ent[W_CRIT][F_ICD] || !is_icmp ||
                  (f_icode == ent[W_ICMP][F_ICODE +: 8]);
  assign ity_ok = !ent[W_CRIT][F_ITY] || !is_icmp ||
                  (f_itype == ent[W_ICMP][F_ITYPE +: 8]);
  assign prt_ok = !l4_ports ||
    ((!ent[W_CRIT][F_SPR] || (f_sport >= ent[W_SPRT][15:0] && f_sport <= ent[W_SPRT][31:16])) &&
     (!ent[W_CRIT][F_DPR] || (f_dport >= ent[W_DPRT][15:0] && f_dport <= ent[W_DPRT][31:16])));
  // mac-kind entries carry no ip address test
  assign adr_ok = (kind == KIND_MAC) ||
                  (acm_addr_ok(f_src, e_src, e_smk) && acm_addr_ok(f_dst, e_dst, e_dmk));

  assign crit_hit = syn_ok && fin_ok && tos_ok && pro_ok && icd_ok && ity_ok &&
                    prt_ok && adr_ok;

  a_syn_set: assert property (@(posedge clk) disable iff (!rst_n)
    (is_tcp && syn_m == FLAG_SET && !f_syn) |-> !crit_hit)
    else $error("syn set entry hit by frame without syn");
  a_syn_unset: assert property (@(posedge clk) disable iff (!rst_n)
    (is_tcp && syn_m == FLAG_UNS && f_syn) |-> !crit_hit)
    else $error("syn unset entry hit by frame with syn");
  a_fin_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (is_tcp && ((fin_m == FLAG_SET && !f_fin) || (fin_m == FLAG_UNS && f_fin))) |-> !crit_hit)
    else $error("fin criterion not honoured");
  a_dscp_cmp: assert property (@(posedge clk) disable iff (!rst_n)
    (tos_m == TOS_DSCP && f_tos[7:2] != ent[W_VAL][5:0]) |-> !crit_hit)
    else $error("dscp mismatch gave a hit");
  a_prec_cmp: assert property (@(posedge clk) disable iff (!rst_n)
    (tos_m == TOS_PREC && f_tos[7:5] != ent[W_VAL][10:8]) |-> !crit_hit)
    else $error("precedence mismatch gave a hit");
  a_proto_cmp: assert property (@(posedge clk) disable iff (!rst_n)
    (pro_m == PRO_VAL && f_proto != ent[W_VAL][23:16]) |-> !crit_hit)
    else $error("protocol mismatch gave a hit");
  a_icode_cmp: assert property (@(posedge clk) disable iff (!rst_n)
    (ent[W_CRIT][F_ICD] && is_icmp && f_icode != ent[W_ICMP][15:8]) |-> !crit_hit)
    else $error("icmp code mismatch gave a hit");
  a_addr_wild: assert property (@(posedge clk) disable iff (!rst_n)
    (crit_hit && kind != KIND_MAC) |-> (((f_src ^ e_src) & ~e_smk) == 128'h0))
    else $error("source address outside wildcard gave a hit");
  a_flag_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (!is_tcp) |-> (crit_hit == (tos_ok && pro_ok && icd_ok && ity_ok && prt_ok && adr_ok)))
    else $error("tcp flags checked on non tcp frame");
endmodule // acm_entry_cmp

/* acm_match_top.sv */
// Purpose: access entry table, per-port list binding and frame classification
// Assumes: frame header fields come from logic on MCLK, one frame per FRM_VALID
// Notes:   result registered one cycle after FRM_VALID; no back-pressure
// Notes on behaviour
// - syn criterion is set, unset or don't-care
// - fin criterion is set, unset or don't-care
// - don't-care flag matches any frame value
// - tos any skips dscp and precedence compare
// - dscp mode requires six-bit equality
// - precedence mode requires three-bit equality
// - protocol any skips; value mode requires equality
// - protocol list mode matches predefined protocol set
// - icmp code any skips code compare
// - user icmp code requires eight-bit equality
// - ipv6 addresses compared outside wildcard mask bits
// - entry stores sequence, action, ranges, flags, icmp
// - bound list governs frames on that port
// - three separate slots per port: mac, ipv4, ipv6
`timescale 1ns/1ps
module acm_match_top
  import acm_pkg::*;
#(
  parameter int N_ENT   = NUM_ENT,
  parameter int N_PORTS = NUM_PORTS
)(
  input  wire logic                     MCLK,
  input  wire logic                     RST_N,
  input  wire logic [ADDR_W-1:0]        AVS_ADDRESS,
  input  wire logic                     AVS_READ,
  input  wire logic                     AVS_WRITE,
  input  wire logic [31:0]              AVS_WRITEDATA,
  input  wire logic [3:0]               AVS_BYTEENABLE,
  output logic [31:0]                   AVS_READDATA,
  output logic                          AVS_WAITREQUEST,
  input  wire logic                     FRM_VALID,
  input  wire logic [$clog2(N_PORTS)-1:0] FRM_PORT,
  input  wire logic                     FRM_IPV6,
  input  wire logic [7:0]               FRM_PROTO,
  input  wire logic [7:0]               FRM_TOS,
  input  wire logic                     FRM_SYN,
  input  wire logic                     FRM_FIN,
  input  wire logic [15:0]              FRM_SPORT,
  input  wire logic [15:0]              FRM_DPORT,
  input  wire logic [7:0]               FRM_ICMP_TYPE,
  input  wire logic [7:0]               FRM_ICMP_CODE,
  input  wire logic [127:0]             FRM_SRC,
  input  wire logic [127:0]             FRM_DST,
  output logic                          RES_VALID,
  output logic                          RES_HIT,
  output logic [1:0]                    RES_ACTION,
  output logic [$clog2(N_ENT)-1:0]      RES_ENTRY
);
  localparam int EW = $clog2(N_ENT);
  localparam int PW = $clog2(N_PORTS);

  logic [31:0]  ent_mem [N_ENT][ENT_WORDS];
  logic [31:0]  bind_r  [N_PORTS];
  logic [31:0]  ctrl_r;
  logic [31:0]  hitcnt_r;
  logic [31:0]  frmcnt_r;
  logic         ack_r;
  logic         req;
  logic         wr_go;
  logic [N_ENT-1:0] crit_hit;
  logic [N_ENT-1:0] elig;
  logic [N_ENT-1:0] hit_vec;
  logic         win_hit;
  logic [EW-1:0] win_idx;
  logic [7:0]   win_seq;
  logic [31:0]  port_bind;

  function automatic logic [31:0] acm_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
    for (int b = 0; b < 4; b++) begin
      acm_merge[b*8 +: 8] = be[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
    end
  endfunction

  // entry window decode, used by write and read paths
  function automatic logic acm_is_ent(input logic [ADDR_W-1:0] a);
    acm_is_ent = (a >= OFS_ENT) &&
      ((a - OFS_ENT) < ADDR_W'(N_ENT * ENT_STRIDE_W * 4)) &&
      ((a[6:2]) < 5'(ENT_WORDS));
  endfunction

  function automatic logic acm_is_bind(input logic [ADDR_W-1:0] a);
    acm_is_bind = (a >= OFS_BIND) && (a < OFS_BIND + ADDR_W'(N_PORTS * 4));
  endfunction

  // bus handshake: one wait cycle, then the access completes
  assign req             = AVS_READ || AVS_WRITE;
  assign AVS_WAITREQUEST = req && !ack_r;
  assign wr_go           = AVS_WRITE && ack_r;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && !ack_r) begin
      AVS_READDATA <= 32'h0000_0000;
      if (AVS_ADDRESS == OFS_CTRL) begin
        AVS_READDATA <= ctrl_r;
      end else if (AVS_ADDRESS == OFS_STAT) begin
        AVS_READDATA <= {16'h0000, 8'(win_seq), 7'h00, RES_HIT};
      end else if (AVS_ADDRESS == OFS_HITCNT) begin
        AVS_READDATA <= hitcnt_r;
      end else if (AVS_ADDRESS == OFS_FRMCNT) begin
        AVS_READDATA <= frmcnt_r;
      end else if (acm_is_bind(AVS_ADDRESS)) begin
        AVS_READDATA <= bind_r[PW'((AVS_ADDRESS - OFS_BIND) >> 2)];
      end else if (acm_is_ent(AVS_ADDRESS)) begin
        AVS_READDATA <= ent_mem[EW'((AVS_ADDRESS - OFS_ENT) >> 7)][AVS_ADDRESS[6:2]];
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_go && AVS_ADDRESS == OFS_CTRL) begin
      ctrl_r <= acm_merge(ctrl_r, AVS_WRITEDATA, AVS_BYTEENABLE) & 32'h0000_0001;
    end
  end

  // one byte per slot so a byte-enable write edits or clears one slot only
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int p = 0; p < N_PORTS; p++) begin
        bind_r[p] <= 32'h0000_0000;
      end
    end else if (wr_go && acm_is_bind(AVS_ADDRESS)) begin
      bind_r[PW'((AVS_ADDRESS - OFS_BIND) >> 2)] <=
        acm_merge(bind_r[PW'((AVS_ADDRESS - OFS_BIND) >> 2)], AVS_WRITEDATA,
                  AVS_BYTEENABLE) & 32'h000F_0F0F;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int e = 0; e < N_ENT; e++) begin
        for (int w = 0; w < ENT_WORDS; w++) begin
          ent_mem[e][w] <= 32'h0000_0000;
        end
      end
    end else if (wr_go && acm_is_ent(AVS_ADDRESS)) begin
      ent_mem[EW'((AVS_ADDRESS - OFS_ENT) >> 7)][AVS_ADDRESS[6:2]] <=
        acm_merge(ent_mem[EW'((AVS_ADDRESS - OFS_ENT) >> 7)][AVS_ADDRESS[6:2]],
                  AVS_WRITEDATA, AVS_BYTEENABLE);
    end
  end

  // per entry: criteria compare, then list binding eligibility
  assign port_bind = bind_r[FRM_PORT];

  genvar gi;
  generate
    for (gi = 0; gi < N_ENT; gi++) begin : g_ent
      logic [1:0] kind;
      logic [7:0] slot;
      assign kind = ent_mem[gi][W_CTRL][F_KIND +: 2];
      // mac list applies to all frames, ip lists only to their own family
      always_comb begin
        unique case (kind)
          KIND_IPV4: slot = FRM_IPV6 ? 8'h00 : port_bind[15:8];
          KIND_IPV6: slot = FRM_IPV6 ? port_bind[23:16] : 8'h00;
          default:   slot = port_bind[7:0];
        endcase
      end
      assign elig[gi] = ent_mem[gi][W_CTRL][F_VALID] && slot[B_VALID] &&
        (slot[B_LIST +: 3] == ent_mem[gi][W_CTRL][F_LIST +: 3]);
      acm_entry_cmp u_cmp (
        .clk      (MCLK),
        .rst_n    (RST_N),
        .ent      (ent_mem[gi]),
        .f_ipv6   (FRM_IPV6),
        .f_proto  (FRM_PROTO),
        .f_tos    (FRM_TOS),
        .f_syn    (FRM_SYN),
        .f_fin    (FRM_FIN),
        .f_sport  (FRM_SPORT),
        .f_dport  (FRM_DPORT),
        .f_itype  (FRM_ICMP_TYPE),
        .f_icode  (FRM_ICMP_CODE),
        .f_src    (FRM_SRC),
        .f_dst    (FRM_DST),
        .crit_hit (crit_hit[gi])
      );
    end
  endgenerate

  assign hit_vec = crit_hit & elig;

  // lowest sequence wins; equal sequence goes to the lower index
  always_comb begin
    win_hit = 1'b0;
    win_idx = '0;
    win_seq = 8'hFF;
    for (int e = 0; e < N_ENT; e++) begin
      if (hit_vec[e] && (!win_hit || ent_mem[e][W_CTRL][F_SEQ +: 8] < win_seq)) begin
        win_hit = 1'b1;
        win_idx = EW'(e);
        win_seq = ent_mem[e][W_CTRL][F_SEQ +: 8];
      end
    end
  end

  // disabled block still answers every frame, with no hit
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      RES_VALID  <= 1'b0;
      RES_HIT    <= 1'b0;
      RES_ACTION <= 2'h0;
      RES_ENTRY  <= '0;
    end else begin
      RES_VALID <= FRM_VALID;
      if (FRM_VALID) begin
        RES_HIT    <= win_hit && ctrl_r[0];
        RES_ACTION <= (win_hit && ctrl_r[0]) ? ent_mem[win_idx][W_CTRL][F_ACT +: 2] : 2'h0;
        RES_ENTRY  <= win_idx;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      hitcnt_r <= 32'h0000_0000;
      frmcnt_r <= 32'h0000_0000;
    end else if (FRM_VALID) begin
      frmcnt_r <= frmcnt_r + 32'h0000_0001;
      if (win_hit && ctrl_r[0]) hitcnt_r <= hitcnt_r + 32'h0000_0001;
    end
  end

  // independent of the winner loop: any hitting entry that should have won instead
  logic seq_beaten;
  always_comb begin
    seq_beaten = 1'b0;
    for (int e = 0; e < N_ENT; e++) begin
      if (hit_vec[e] && ((ent_mem[e][W_CTRL][F_SEQ +: 8] < win_seq) ||
          ((ent_mem[e][W_CTRL][F_SEQ +: 8] == win_seq) && (EW'(e) < win_idx)))) begin
        seq_beaten = 1'b1;
      end
    end
  end

  sequence s_frame_hit;
    FRM_VALID && ctrl_r[0] && win_hit;
  endsequence

  a_result_hit: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_frame_hit |=> (RES_VALID && RES_HIT && RES_ENTRY == $past(win_idx)))
    else $error("hit frame did not report its entry");
  a_lowest_seq: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_frame_hit |-> (!seq_beaten && hit_vec[win_idx]))
    else $error("reported entry not the lowest sequence");
  a_unbound_miss: assert property (@(posedge MCLK) disable iff (!RST_N)
    (FRM_VALID && port_bind[3] == 1'b0 && port_bind[11] == 1'b0 && port_bind[19] == 1'b0)
      |=> !RES_HIT)
    else $error("frame on port without bound lists hit an entry");
  a_bus_answer: assert property (@(posedge MCLK) disable iff (!RST_N)
    ($rose(req) && !ack_r) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("bus access not answered after one wait cycle");
endmodule // acm_match_top

/* acm_frm_src.sv */
// Purpose: ingress header source standing in for switch port receive logic
// Assumes: one header per send call, a one-cycle valid pulse on clk
// Notes:   fields are inverted between frames so stale values never match
`timescale 1ns/1ps
module acm_frm_src (
  input  wire logic   clk,
  output logic        vld,
  output logic [2:0]  port,
  output logic        ipv6,
  output logic [7:0]  proto,
  output logic [7:0]  tos,
  output logic        syn,
  output logic        fin,
  output logic [7:0]  icode,
  output logic [127:0] src,
  output logic [15:0]  sport,
  output logic [15:0]  dport,
  output logic [7:0]   itype,
  output logic [127:0] dst
);
  initial begin
    vld = 1'b0;
    {port, ipv6, proto, tos, syn, fin, icode, src, sport, dport, itype, dst} = '1;
  end

  task automatic send(input logic [2:0] p, input logic v6, input logic [7:0] pr,
                      input logic [7:0] ts, input logic s, input logic f,
                      input logic [7:0] ic, input logic [127:0] sa,
                      input logic [15:0] sp, input logic [15:0] dp,
                      input logic [7:0] it, input logic [127:0] da);
    @(posedge clk);
    vld <= 1'b1;
    {port, ipv6, proto, tos, syn, fin, icode, src, sport, dport, itype, dst} <=
      {p, v6, pr, ts, s, f, ic, sa, sp, dp, it, da};
    @(posedge clk);
    vld <= 1'b0;
    {port, ipv6, proto, tos, syn, fin, icode, src, sport, dport, itype, dst} <=
      ~{p, v6, pr, ts, s, f, ic, sa, sp, dp, it, da};
  endtask
endmodule // acm_frm_src

/* testbench.sv */
// Purpose: self-checking bench for the entry match and port binding block
// Assumes: one wait cycle per bus access, result one edge after a frame
// Notes:   criteria rows reuse entry 0; binding and priority cases follow
`timescale 1ns/1ps
module testbench
  import acm_pkg::*;
;
  typedef struct packed {
    logic [15:0] crit;
    logic [31:0] val;
    logic [15:0] icmp;
    logic [7:0]  pro;
    logic [7:0]  tos;
    logic        syn;
    logic        fin;
    logic [7:0]  ic;
    logic        hit;
  } acm_row_s;

  logic        MCLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic [11:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rdat;
  logic [3:0]  AVS_BYTEENABLE;
  logic        fv, f6, fs, ff, RES_VALID, RES_HIT;
  logic [2:0]  fp, RES_ENTRY;
  logic [7:0]  fpr, ftos, fic;
  logic [127:0] fsrc, fdst;
  logic [15:0] fsp, fdp;
  logic [7:0]  fit;
  logic [1:0]  RES_ACTION;
  logic [6:0]  res;
  int          bad_count, total_checks, cyc;

  // {crit, val, icmp, proto, tos, syn, fin, icode, hit}; entry 0 ipv4 action 2
  acm_row_s rows [19] = '{
    '{16'h1, 0, 0, 8'h06, 0, 1, 0, 0, 1}, '{16'h1, 0, 0, 8'h06, 0, 0, 0, 0, 0},
    '{16'h2, 0, 0, 8'h06, 0, 1, 0, 0, 0}, '{16'h4, 0, 0, 8'h06, 0, 0, 1, 0, 1},
    '{16'h8, 0, 0, 8'h06, 0, 0, 1, 0, 0}, '{16'h0, 0, 0, 8'h06, 0, 1, 1, 0, 1},
    '{16'h10, 32'h3F, 0, 8'h06, 8'hFC, 0, 0, 0, 1},
    '{16'h10, 32'h3F, 0, 8'h06, 8'hF8, 0, 0, 0, 0},
    '{16'h20, 32'h700, 0, 8'h06, 8'hE0, 0, 0, 0, 1},
    '{16'h20, 32'h700, 0, 8'h06, 8'hC0, 0, 0, 0, 0},
    '{16'h0, 32'h3F, 0, 8'h06, 8'h55, 0, 0, 0, 1},
    '{16'h40, 32'h110000, 0, 8'h11, 0, 0, 0, 0, 1},
    '{16'h40, 32'h110000, 0, 8'h06, 0, 0, 0, 0, 0},
    '{16'h80, 32'h0800_0000, 0, 8'h11, 0, 0, 0, 0, 1},
    '{16'h80, 32'h0800_0000, 0, 8'h06, 0, 0, 0, 0, 0},
    '{16'h100, 0, 16'hFF00, 8'h01, 0, 0, 0, 8'hFF, 1},
    '{16'h100, 0, 16'hFF00, 8'h01, 0, 0, 0, 8'hFE, 0},
    '{16'h0, 0, 16'hFF00, 8'h01, 0, 0, 0, 8'h12, 1},
    '{16'h1, 0, 0, 8'h11, 0, 0, 0, 0, 1}};

  acm_match_top acm_match_top_inst (.MCLK(MCLK), .RST_N(RST_N),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .FRM_VALID(fv), .FRM_PORT(fp), .FRM_IPV6(f6), .FRM_PROTO(fpr), .FRM_TOS(ftos),
    .FRM_SYN(fs), .FRM_FIN(ff), .FRM_SPORT(fsp), .FRM_DPORT(fdp),
    .FRM_ICMP_TYPE(fit), .FRM_ICMP_CODE(fic), .FRM_SRC(fsrc), .FRM_DST(fdst),
    .RES_VALID(RES_VALID), .RES_HIT(RES_HIT), .RES_ACTION(RES_ACTION),
    .RES_ENTRY(RES_ENTRY));

  acm_frm_src acm_frm_src_inst (.clk(MCLK), .vld(fv), .port(fp), .ipv6(f6),
    .proto(fpr), .tos(ftos), .syn(fs), .fin(ff), .icode(fic), .src(fsrc),
    .sport(fsp), .dport(fdp), .itype(fit), .dst(fdst));

  always #50 MCLK = ~MCLK;

  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end

  function automatic logic [11:0] ea(input int e, input int w);
    ea = OFS_ENT + 12'(e * 128 + w * 4);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // holds the request until waitrequest is low at a rising edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge MCLK);
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= be;
    do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
    rdat = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask

  task automatic run(input logic [2:0] p, input logic v6, input logic [7:0] pr,
                     input logic [7:0] ts, input logic s, input logic f,
                     input logic [7:0] ic, input logic [127:0] sa,
                     input logic [15:0] sp = 16'h0000, input logic [15:0] dp = 16'h0000,
                     input logic [7:0] it = 8'h00, input logic [127:0] da = 128'h0);
    acm_frm_src_inst.send(p, v6, pr, ts, s, f, ic, sa, sp, dp, it, da);
    @(negedge MCLK);
    res = {RES_VALID, RES_HIT, RES_ACTION, RES_ENTRY};
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    {MCLK, RST_N, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA, AVS_BYTEENABLE} = '0;
    repeat (6) @(posedge MCLK);
    RST_N <= 1'b1;
    bus(0, OFS_CTRL, 0, 4'hF);
    chk(rdat, CTRL_RST);
    bus(0, 12'h020, 0, 4'hF);
    chk(rdat, 0);
    bus(1, OFS_CTRL, 32'h1, 4'hF);
    bus(1, OFS_BIND + 12'h8, 32'h0000_0900, 4'hF);
    bus(1, ea(0, 0), 32'h58B, 4'hF);
    foreach (rows[i]) begin
      bus(1, ea(0, 1), {16'h0, rows[i].crit}, 4'hF);
      bus(1, ea(0, 2), rows[i].val, 4'hF);
      bus(1, ea(0, 3), {16'h0, rows[i].icmp}, 4'hF);
      run(2, 0, rows[i].pro, rows[i].tos, rows[i].syn, rows[i].fin, rows[i].ic, 0);
      chk(res, {1'b1, rows[i].hit, rows[i].hit, 4'h0});
    end
    // port ranges, end points included
    bus(1, ea(0, 1), 32'hC00, 4'hF);
    bus(1, ea(0, 4), 32'h0050_0010, 4'hF);
    bus(1, ea(0, 5), 32'h0050_0010, 4'hF);
    run(2, 0, 8'h11, 0, 0, 0, 0, 0, 16'h0050, 16'h0010);
    chk(res, 7'h70);
    run(2, 0, 8'h11, 0, 0, 0, 0, 0, 16'h0051, 16'h0010);
    chk(res, 7'h40);
    run(2, 0, 8'h11, 0, 0, 0, 0, 0, 16'h0050, 16'h000F);
    chk(res, 7'h40);
    bus(1, ea(0, 1), 32'h200, 4'hF);
    bus(1, ea(0, 3), 32'h0000_0008, 4'hF);
    run(2, 0, 8'h01, 0, 0, 0, 0, 0, 16'h0000, 16'h0000, 8'h08);
    chk(res, 7'h70);
    run(2, 0, 8'h01, 0, 0, 0, 0, 0, 16'h0000, 16'h0000, 8'h09);
    chk(res, 7'h40);
    // lower sequence number on entry 1 must beat entry 0
    bus(1, ea(0, 1), 0, 4'hF);
    bus(1, ea(1, 0), 32'h34B, 4'hF);
    bus(0, ea(1, 0), 0, 4'hF);
    chk(rdat, 32'h34B);
    run(2, 0, 8'h11, 0, 0, 0, 0, 0);
    chk(res, 7'h69);
    run(3, 0, 8'h11, 0, 0, 0, 0, 0);
    chk(res, 7'h40);
    bus(1, OFS_BIND + 12'h8, 32'h000C_0000, 4'h4);
    bus(1, ea(2, 0), 32'h10E5, 4'hF);
    bus(1, ea(2, 6), 32'hA, 4'hF);
    bus(1, ea(2, 10), 32'hF, 4'hF);
    run(2, 1, 8'h11, 0, 0, 0, 0, 128'h5);
    chk(res, 7'h7A);
    run(2, 1, 8'h11, 0, 0, 0, 0, 128'h15);
    chk(res, 7'h40);
    run(2, 1, 8'h11, 0, 0, 0, 0, 128'h5, 16'h0000, 16'h0000, 8'h00, 128'h1);
    chk(res, 7'h40);
    run(2, 0, 8'h11, 0, 0, 0, 0, 0);
    chk(res, 7'h69);
    // removing only the ipv4 slot leaves the ipv6 slot bound
    bus(1, OFS_BIND + 12'h8, 0, 4'h2);
    run(2, 0, 8'h11, 0, 0, 0, 0, 0);
    chk(res, 7'h40);
    run(2, 1, 8'h11, 0, 0, 0, 0, 128'h5);
    chk(res, 7'h7A);
    bus(1, OFS_CTRL, 0, 4'hF);
    run(2, 1, 8'h11, 0, 0, 0, 0, 128'h5);
    chk(res[6:5], 2'h2);
    bus(0, OFS_FRMCNT, 0, 4'hF);
    chk(rdat, 32'h21);
    bus(0, OFS_HITCNT, 0, 4'hF);
    chk(rdat, 32'h11);
    // reset in mid-run clears results and bindings
    RST_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    chk({RES_VALID, RES_HIT, RES_ACTION, RES_ENTRY}, 0);
    bus(0, OFS_BIND + 12'h8, 0, 4'hF);
    chk(rdat, 0);
    report_and_stop();
  end
endmodule // testbench
